// *** logic/rpm_consts.vh ***
// constants for the reset and power mode controller
`ifndef RPM_CONSTS_VH
`define RPM_CONSTS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define RPM_ADDR_W          8
`define RPM_ADDR_PWR_CTRL   8'h87
`define RPM_ADDR_RST_SRC    8'hEF
`define RPM_ADDR_MON_CTRL   8'hFF
`define RPM_ADDR_IRQ_STAT   8'hE0
`define RPM_ADDR_IRQ_MASK   8'hE1

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define RPM_PC_GF_HI        7
`define RPM_PC_GF_LO        2
`define RPM_PC_STOP         1
`define RPM_PC_IDLE         0
`define RPM_RS_POR          1
`define RPM_MC_EN           7
`define RPM_MC_STAT         6
`define RPM_IRQ_W           3
`define RPM_IRQ_IDLE        0
`define RPM_IRQ_STOP        1
`define RPM_IRQ_MON         2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RPM_GF_RST          6'h00
`define RPM_PORT_RST        8'hFF
`define RPM_PC_RST          16'h0000
`define RPM_BYTE_ZERO       8'h00
`define RPM_IRQ_ZERO        3'h0
`define RPM_WDT_DIV         4'hB

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RPM_CLK_MHZ         100
`define RPM_POR_DELAY_US    300
`define RPM_CNT_W           16

`endif

// *** logic/rpm_ctrl.v ***
// reset and power mode controller: reset combining, cause flags, power control register
// Contract
// - power control bits 7:2 are six software flags with no hardware effect.
// - writing 1 to bit 1 enters stop mode, oscillator halted; reads 0.
// - writing 1 to bit 0 gates only the cpu clock; reads 0.
// - in reset: halt cpu, registers to defaults, ports known, interrupts and timers off; interrupt status kept except on nrst.
// - data memory kept across reset; stack pointer reinitialised.
// - port latches load 0xFF open-drain; weak pull-ups on during and after reset.
// - power-on and monitor resets drive the reset pin low while in reset.
// - leaving reset: pc cleared, internal oscillator selected, fetch from zero.
// - leaving reset: watchdog enabled, clocked from system clock divided by twelve.
// - power-up held in reset until supply good, then extra release delay.
// - power-on or monitor reset sets power-on flag; other causes clear it.
// - other cause flags undefined while power-on flag is set.
// - only power-on reset enables the supply monitor; other resets keep state.
// - supply below threshold holds reset and drives pin low until it recovers.
// - monitor reset releases without the power-on delay.
// - monitor enable is bit 7 of the monitor control register.
`include "rpm_consts.vh"

module rpm_ctrl #(
  parameter [`RPM_CNT_W-1:0] POR_DELAY_CYC = (`RPM_POR_DELAY_US * `RPM_CLK_MHZ)
) (
  input  wire                   clk_sys,
  input  wire                   nrst,
  input  wire                   clk_en,
  input  wire                   supply_good,
  input  wire                   other_rst_req,
  input  wire [`RPM_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  output wire                   irq,
  output wire                   rst_pin_o,
  output wire                   rst_pin_oe,
  output wire                   core_rst,
  output wire                   cpu_clk_gate,
  output wire                   osc_halt,
  output reg  [7:0]             port_latch,
  output wire                   port_open_drain,
  output wire                   weak_pullup_en,
  output wire                   sp_reinit,
  output wire [15:0]            pc_reset_value,
  output wire                   sel_int_osc,
  output wire                   wdt_enable,
  output wire [3:0]             wdt_div_m1,
  output wire                   irq_timer_disable,
  output wire                   supply_mon_en
);

  // ----------------------------------------------------------------
  // states, one-hot
  // ----------------------------------------------------------------
  localparam [3:0] ST_POR   = 4'h1;
  localparam [3:0] ST_DELAY = 4'h2;
  localparam [3:0] ST_RUN   = 4'h4;
  localparam [3:0] ST_MON   = 4'h8;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // the supply level is asynchronous to clk_sys; two flops before use
  reg        sg_meta_q;
  reg        sg_q;
  reg        orr_meta_q;
  reg        orr_q;
  // nrst release synchronised so the state and counter flops leave together
  reg        rel_meta_q;
  reg        rel_q;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rel_meta_q <= 1'b0;
      rel_q      <= 1'b0;
    end else begin
      rel_meta_q <= 1'b1;
      rel_q      <= rel_meta_q;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sg_meta_q  <= 1'b0;
      sg_q       <= 1'b0;
      orr_meta_q <= 1'b0;
      orr_q      <= 1'b0;
    end else if (clk_en) begin
      sg_meta_q  <= supply_good;
      sg_q       <= sg_meta_q;
      orr_meta_q <= other_rst_req;
      orr_q      <= orr_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  reg [3:0]             state_q;
  reg [3:0]             state_d;
  reg [`RPM_CNT_W-1:0]  cnt_q;
  reg [`RPM_CNT_W-1:0]  cnt_d;
  reg [5:0]             gflags_q;
  reg                   idle_q;
  reg                   stop_q;
  reg                   por_flag_q;
  reg                   mon_en_q;
  reg [`RPM_IRQ_W-1:0]  stat_q;
  reg [`RPM_IRQ_W-1:0]  mask_q;
  reg                   in_rst_q;

  // monitor counts only when enabled; a disabled monitor never resets
  wire mon_fail = mon_en_q & ~sg_q;
  wire running  = state_q[2];
  wire soft_rst = running & orr_q;

  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_POR: begin
        cnt_d = {`RPM_CNT_W{1'b0}};
        if (sg_q) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        cnt_d = cnt_q + {{(`RPM_CNT_W-1){1'b0}}, 1'b1};
        if (!sg_q) begin
          state_d = ST_POR;
        end else if (cnt_q >= POR_DELAY_CYC - {{(`RPM_CNT_W-1){1'b0}}, 1'b1}) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (mon_fail) begin
          state_d = ST_MON;
        end
      end
      ST_MON: begin
        if (sg_q) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_POR;
      cnt_q   <= {`RPM_CNT_W{1'b0}};
    end else if (!rel_q) begin
      state_q <= ST_POR;
      cnt_q   <= {`RPM_CNT_W{1'b0}};
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // power control, cause flag, monitor enable
  // ----------------------------------------------------------------
  wire wr_pc  = reg_wr & (reg_addr == `RPM_ADDR_PWR_CTRL);
  wire wr_rs  = reg_wr & (reg_addr == `RPM_ADDR_RST_SRC);
  wire wr_mc  = reg_wr & (reg_addr == `RPM_ADDR_MON_CTRL);
  wire wr_msk = reg_wr & (reg_addr == `RPM_ADDR_IRQ_MASK);
  wire rd_st  = reg_rd & (reg_addr == `RPM_ADDR_IRQ_STAT);

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gflags_q   <= `RPM_GF_RST;
      idle_q     <= 1'b0;
      stop_q     <= 1'b0;
      por_flag_q <= 1'b1;
      mon_en_q   <= 1'b1;
      mask_q     <= `RPM_IRQ_ZERO;
      in_rst_q   <= 1'b1;
    end else if (clk_en) begin
      in_rst_q <= ~running | soft_rst;
      if (!running) begin
        gflags_q <= `RPM_GF_RST;
        idle_q   <= 1'b0;
        stop_q   <= 1'b0;
        mask_q   <= `RPM_IRQ_ZERO;
        por_flag_q <= 1'b1;
        if (state_q[0]) begin
          mon_en_q <= 1'b1;
        end
      end else if (soft_rst) begin
        // other causes reset registers but leave the monitor alone
        gflags_q   <= `RPM_GF_RST;
        idle_q     <= 1'b0;
        stop_q     <= 1'b0;
        mask_q     <= `RPM_IRQ_ZERO;
        por_flag_q <= 1'b0;
      end else begin
        if (wr_pc) begin
          gflags_q <= reg_wdata[`RPM_PC_GF_HI:`RPM_PC_GF_LO];
          if (reg_wdata[`RPM_PC_IDLE]) begin
            idle_q <= 1'b1;
          end
          if (reg_wdata[`RPM_PC_STOP]) begin
            stop_q <= 1'b1;
          end
        end
        // writing bit 1 loads the power-on flag directly; nothing else uses it
        if (wr_rs) begin
          por_flag_q <= reg_wdata[`RPM_RS_POR];
        end
        if (wr_mc) begin
          mon_en_q <= reg_wdata[`RPM_MC_EN];
        end
        if (wr_msk) begin
          mask_q <= reg_wdata[`RPM_IRQ_W-1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status: set wins over read-clear
  // ----------------------------------------------------------------
  wire [`RPM_IRQ_W-1:0] ev;
  assign ev[`RPM_IRQ_IDLE] = wr_pc & reg_wdata[`RPM_PC_IDLE] & running;
  assign ev[`RPM_IRQ_STOP] = wr_pc & reg_wdata[`RPM_PC_STOP] & running;
  assign ev[`RPM_IRQ_MON]  = running & mon_fail;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stat_q <= `RPM_IRQ_ZERO;
    end else if (clk_en) begin
      stat_q <= (rd_st ? `RPM_IRQ_ZERO : stat_q) | ev;
    end
  end

  assign irq = |(stat_q & mask_q);

  // ----------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `RPM_BYTE_ZERO;
    end else if (clk_en) begin
      reg_rdata <= `RPM_BYTE_ZERO;
      if (reg_rd) begin
        if (reg_addr == `RPM_ADDR_PWR_CTRL) begin
          reg_rdata <= {gflags_q, 2'b00};
        end else if (reg_addr == `RPM_ADDR_RST_SRC) begin
          // other cause bits are not modelled and read 0
          reg_rdata <= {6'h00, por_flag_q, 1'b0};
        end else if (reg_addr == `RPM_ADDR_MON_CTRL) begin
          reg_rdata <= {mon_en_q, sg_q, 6'h00};
        end else if (reg_addr == `RPM_ADDR_IRQ_STAT) begin
          reg_rdata <= {5'h00, stat_q};
        end else if (reg_addr == `RPM_ADDR_IRQ_MASK) begin
          reg_rdata <= {5'h00, mask_q};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // port latches
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      port_latch <= `RPM_PORT_RST;
    end else if (clk_en && in_rst_q) begin
      port_latch <= `RPM_PORT_RST;
    end
  end

  // ----------------------------------------------------------------
  // outputs to the core
  // ----------------------------------------------------------------
  // open-drain pin: only ever pulled low, never driven high
  assign rst_pin_o         = 1'b0;
  assign rst_pin_oe        = ~running;
  assign core_rst          = in_rst_q;
  assign cpu_clk_gate      = idle_q | stop_q;
  assign osc_halt          = stop_q;
  assign port_open_drain   = in_rst_q;
  assign weak_pullup_en    = 1'b1;
  // data memory has no reset path here; only the stack pointer reloads
  assign sp_reinit         = in_rst_q;
  assign pc_reset_value    = `RPM_PC_RST;
  assign sel_int_osc       = in_rst_q;
  assign wdt_enable        = 1'b1;
  assign wdt_div_m1        = `RPM_WDT_DIV;
  assign irq_timer_disable = in_rst_q;
  assign supply_mon_en     = mon_en_q;

endmodule

// *** sim/rpm_ctrl_props.sv ***
// concurrent checks on the controller's ports
module rpm_ctrl_props (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        clk_en,
  input wire logic        supply_good,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        rst_pin_o,
  input wire logic        rst_pin_oe,
  input wire logic        core_rst,
  input wire logic        cpu_clk_gate,
  input wire logic        osc_halt,
  input wire logic [7:0]  port_latch,
  input wire logic        port_open_drain,
  input wire logic        weak_pullup_en,
  input wire logic        sp_reinit,
  input wire logic [15:0] pc_reset_value,
  input wire logic        sel_int_osc,
  input wire logic        wdt_enable,
  input wire logic [3:0]  wdt_div_m1,
  input wire logic        irq_timer_disable,
  input wire logic        supply_mon_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  pin_never_high_a: assert property (rst_pin_o == 1'b0)
    else $error("reset pin driven high");
  pin_in_reset_a: assert property (rst_pin_oe |-> ##1 core_rst)
    else $error("reset pin low outside reset");
  mode_bits_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h87 |->
    reg_rdata[1:0] == 2'b00) else $error("mode bits read nonzero");
  ports_known_a: assert property (core_rst |-> port_latch == 8'hFF && port_open_drain
    && weak_pullup_en) else $error("port state wrong in reset");
  reset_ties_a: assert property (irq_timer_disable == core_rst && sp_reinit == core_rst
    && sel_int_osc == core_rst) else $error("reset outputs disagree");
  exit_defaults_a: assert property ($fell(core_rst) |-> pc_reset_value == 16'h0000 &&
    wdt_enable && wdt_div_m1 == 4'hB) else $error("exit defaults wrong");
  stop_gates_a: assert property (osc_halt |-> cpu_clk_gate)
    else $error("stop without cpu clock gate");
  mon_trip_a: assert property ($fell(supply_good) && supply_mon_en && !core_rst && clk_en
    |-> ##[1:5] (rst_pin_oe && core_rst)) else $error("supply fail missed");
endmodule

bind rpm_ctrl rpm_ctrl_props u_props (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
  .supply_good(supply_good), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .core_rst(core_rst),
  .cpu_clk_gate(cpu_clk_gate), .osc_halt(osc_halt), .port_latch(port_latch),
  .port_open_drain(port_open_drain), .weak_pullup_en(weak_pullup_en),
  .sp_reinit(sp_reinit), .pc_reset_value(pc_reset_value), .sel_int_osc(sel_int_osc),
  .wdt_enable(wdt_enable), .wdt_div_m1(wdt_div_m1),
  .irq_timer_disable(irq_timer_disable), .supply_mon_en(supply_mon_en));

// *** sim/rpm_supply_model.sv ***
// supply comparator and reset pin model
module rpm_supply_model (
  input  wire logic clk_sys,
  input  wire logic vdd_ok,
  input  wire logic rst_pin_o,
  input  wire logic rst_pin_oe,
  output logic      supply_good,
  output wire logic rst_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial supply_good = 1'b0;
  // moves just after an edge; the controller must synchronise it anyway
  always @(posedge clk_sys) supply_good <= vdd_ok;
  // external pull-up holds the pin high unless the controller pulls it
  assign rst_pin = rst_pin_oe ? rst_pin_o : 1'b1;
endmodule

// *** sim/test_reset_and_power_mode_control.sv ***
// self-checking bench for the reset and power mode controller
`include "rpm_consts.vh"
module test_reset_and_power_mode_control;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DLY = 20;
  logic        clk_sys = 1'b0, nrst = 1'b0, clk_en = 1'b1, vdd_ok = 1'b0;
  logic        other_rst_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, port_latch;
  logic        supply_good, rst_pin, irq, rst_pin_o, rst_pin_oe, core_rst, cpu_clk_gate;
  logic        osc_halt, port_open_drain, weak_pullup_en, sp_reinit, sel_int_osc;
  logic        wdt_enable, irq_timer_disable, supply_mon_en;
  logic [15:0] pc_reset_value;
  logic [3:0]  wdt_div_m1;
  int          err_count = 0, n_compared = 0;

  rpm_ctrl #(.POR_DELAY_CYC(16'h0014)) DUT (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
    .supply_good(supply_good), .other_rst_req(other_rst_req), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .core_rst(core_rst),
    .cpu_clk_gate(cpu_clk_gate), .osc_halt(osc_halt), .port_latch(port_latch),
    .port_open_drain(port_open_drain), .weak_pullup_en(weak_pullup_en),
    .sp_reinit(sp_reinit), .pc_reset_value(pc_reset_value), .sel_int_osc(sel_int_osc),
    .wdt_enable(wdt_enable), .wdt_div_m1(wdt_div_m1),
    .irq_timer_disable(irq_timer_disable), .supply_mon_en(supply_mon_en));
  rpm_supply_model u_supply (.clk_sys(clk_sys), .vdd_ok(vdd_ok), .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe), .supply_good(supply_good), .rst_pin(rst_pin));

  always #5 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, m, exp, input string nm);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata & m, exp);
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // bounded wait for the core to leave reset, counting cycles
  task automatic wait_run(output int n);
    n = 0;
    while (core_rst !== 1'b0 && n < 200) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  task automatic other_reset();
    int n;
    @(posedge clk_sys) other_rst_req <= 1'b1;
    edges(5);
    chk("oth_pin", 8'(rst_pin), 8'h01);
    @(posedge clk_sys) other_rst_req <= 1'b0;
    wait_run(n);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up();
    int n;
    edges(20);
    chk("held", 8'(core_rst), 8'h01);
    chk("por_pin", 8'(rst_pin), 8'h00);
    @(posedge clk_sys) vdd_ok <= 1'b1;
    wait_run(n);
    chk("por_delay", 8'(n >= DLY && n <= DLY + 8), 8'h01);
    chk("pin_free", 8'(rst_pin), 8'h01);
    rd(`RPM_ADDR_PWR_CTRL, 8'hFF, 8'h00, "pc_rst");
    rd(`RPM_ADDR_RST_SRC, 8'h02, 8'h02, "por_flag");
    rd(`RPM_ADDR_MON_CTRL, 8'h80, 8'h80, "mon_on");
  endtask
  task automatic t_power_control();
    wr(`RPM_ADDR_PWR_CTRL, 8'hA8);
    rd(`RPM_ADDR_PWR_CTRL, 8'hFF, 8'hA8, "gf_a");
    @(posedge clk_sys) clk_en <= 1'b0;
    wr(`RPM_ADDR_PWR_CTRL, 8'h54);
    clk_en <= 1'b1; // nonblocking so the flops still see clk_en low at this edge
    rd(`RPM_ADDR_PWR_CTRL, 8'hFF, 8'hA8, "frozen");
    wr(`RPM_ADDR_PWR_CTRL, 8'h55);
    #1 chk("idle", {6'h00, cpu_clk_gate, osc_halt}, 8'h02);
    rd(`RPM_ADDR_PWR_CTRL, 8'hFF, 8'h54, "gf_b");
    chk("irq_mask", 8'(irq), 8'h00);
    wr(`RPM_ADDR_IRQ_MASK, 8'h07);
    #1 chk("irq_on", 8'(irq), 8'h01);
    rd(`RPM_ADDR_IRQ_STAT, 8'h07, 8'h01, "stat");
    chk("irq_clr", 8'(irq), 8'h00);
    wr(`RPM_ADDR_PWR_CTRL, 8'h02);
    #1 chk("stop", {6'h00, cpu_clk_gate, osc_halt}, 8'h03);
    rd(`RPM_ADDR_PWR_CTRL, 8'hFF, 8'h00, "stop_rd");
    other_reset();
    chk("latch", port_latch, 8'hFF);
    chk("mode_clr", {6'h00, cpu_clk_gate, osc_halt}, 8'h00);
    rd(`RPM_ADDR_RST_SRC, 8'h02, 8'h00, "por_clr");
    rd(`RPM_ADDR_MON_CTRL, 8'h80, 8'h80, "mon_kept");
  endtask
  task automatic t_monitor();
    int n;
    wr(`RPM_ADDR_MON_CTRL, 8'h00);
    rd(`RPM_ADDR_MON_CTRL, 8'h80, 8'h00, "mon_off");
    @(posedge clk_sys) vdd_ok <= 1'b0;
    edges(8);
    chk("mon_idle", 8'(core_rst), 8'h00);
    @(posedge clk_sys) vdd_ok <= 1'b1;
    other_reset();
    rd(`RPM_ADDR_MON_CTRL, 8'h80, 8'h00, "off_kept");
    wr(`RPM_ADDR_MON_CTRL, 8'h80);
    edges(4); // settle before setting the power-on flag by a write
    wr(`RPM_ADDR_RST_SRC, 8'h02);
    @(posedge clk_sys) vdd_ok <= 1'b0;
    edges(6);
    chk("mon_rst", {6'h00, core_rst, rst_pin}, 8'h02);
    @(posedge clk_sys) vdd_ok <= 1'b1;
    wait_run(n);
    chk("no_delay", 8'(n < DLY), 8'h01);
    rd(`RPM_ADDR_RST_SRC, 8'h02, 8'h02, "mon_flag");
    rd(8'h10, 8'hFF, 8'h00, "unmapped");
  endtask

  task automatic stop_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    t_power_up();
    t_power_control();
    t_monitor();
    stop_test();
  end
endmodule
